// ### logic/rpsel_defs.svh
/*
  Constants of the remappable input pin select block: register map,
  pin numbering, reset values and fixed masks.
  Assumes inclusion by every design file that needs them.
*/
`ifndef RPSEL_DEFS_SVH
`define RPSEL_DEFS_SVH

`define RPS_NUM_PERIPH 21
`define RPS_NUM_PINS 43
`define RPS_SEL_W 4
`define RPS_PIN_IDX_W 6
`define RPS_SEL_RESET 4'h0
`define RPS_LEVEL_IDX 21
`define RPS_DATA_W 32
`define RPS_RESP_OKAY 2'h0
`define RPS_RESP_DECERR 2'h3
`define RPS_FIRST_GRP_B 3
`define RPS_FIRST_GRP_C 7
`define RPS_PER_UART5_CTS 5
`define RPS_BASE_B 6'h0e
`define RPS_BASE_C 6'h1c
`define RPS_PIN_F2 6'h0d
`define RPS_PIN_F7 6'h1b
`define RPS_PIN_F6 42
`define RPS_IDLE_HIGH 21'h1c0c38
`define RPS_CN_CAPABLE 43'h3ff_ffff_ffff
`define RPS_OUT_REMAP_OK 43'h3ff_f7ff_ffff

`endif

// ### logic/rpsel_pkg.sv
/*
  Types of the remappable input pin select block.
  Assumes the constants header is compiled alongside.
*/
package rpsel_pkg;

  typedef enum logic [1:0] {
    RPSEL_GRP_A = 2'b00,
    RPSEL_GRP_B = 2'b01,
    RPSEL_GRP_C = 2'b10
  } rpsel_grp_t;

  typedef struct packed {
    logic ok;
    logic hpc;
    logic [5:0] pin;
  } rpsel_route_t;

  typedef struct packed {
    logic spi_one_slave_select_in;
    logic uart_two_clear_to_send;
    logic uart_one_clear_to_send;
    logic capture_five_in;
    logic capture_two_in;
    logic timer_four_ext_clock;
    logic ext_interrupt_two_in;
    logic spi_two_data_in;
    logic spi_one_data_in;
    logic uart_four_clear_to_send;
    logic uart_three_receive_in;
    logic capture_four_in;
    logic timer_five_ext_clock;
    logic ext_interrupt_four_in;
    logic reference_clock_in;
    logic uart_five_clear_to_send;
    logic uart_two_receive_in;
    logic uart_one_receive_in;
    logic capture_three_in;
    logic timer_two_ext_clock;
    logic ext_interrupt_three_in;
  } rpsel_periph_t;

endpackage

// ### logic/rpsel_top.sv
/*
  Remappable input pin select: 21 select registers on AXI4-Lite steer
  synchronised remappable pins onto peripheral inputs.
  Assumes pins are asynchronous to sys_clk_in and the variant is fixed
  at build time by parameters.
*/
`timescale 1ns/10ps
`include "rpsel_defs.svh"

module rpsel_top #(
  parameter bit PIN_COUNT_100 = 1'b1,
  parameter bit USB_VARIANT = 1'b0,
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [`RPS_DATA_W-1:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [ADDR_W-1:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [`RPS_DATA_W-1:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [`RPS_NUM_PINS-1:0] remappable_pin_in,
  output rpsel_pkg::rpsel_periph_t periph_out,
  output logic [`RPS_NUM_PINS-1:0] change_notify_pins_out,
  output logic [`RPS_NUM_PINS-1:0] out_remap_ok_out
);

  localparam int NPER = `RPS_NUM_PERIPH;
  localparam int NPIN = `RPS_NUM_PINS;
  localparam int IW = ADDR_W - 2;
  localparam logic [IW-1:0] NPER_IDX = IW'(NPER);
  localparam logic [IW-1:0] LEVEL_IDX = IW'(`RPS_LEVEL_IDX);
  localparam logic [NPER-1:0] IDLE = `RPS_IDLE_HIGH;
  localparam bit HAS_F2 = PIN_COUNT_100 || !USB_VARIANT;
  localparam bit HAS_F7 = PIN_COUNT_100 && !USB_VARIANT;

  // Pin synchronisers; first stage feeds only the second
  logic [NPIN-1:0] pin_s1;
  logic [NPIN-1:0] pin_s2;
  logic [NPIN-1:0] pin_s3;
  logic [NPIN-1:0] pin_lvl;
  logic [NPIN-1:0] pin_agree;
  logic [NPIN-1:0] next_pin_lvl;

  // Glitch filter: a change counts once stages two and three agree
  assign pin_agree = ~(pin_s2 ^ pin_s3);
  assign next_pin_lvl = (pin_lvl & ~pin_agree) | (pin_s3 & pin_agree);

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pin_lvl <= '0;
    end else begin
      pin_s1 <= remappable_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_lvl <= next_pin_lvl;
    end
  end

  // Pin index of each code; pins 0-13 group A, 14-27 group B, 28-41 group C, 42 is F6
  function automatic rpsel_pkg::rpsel_route_t route_of(input rpsel_pkg::rpsel_grp_t grp,
                                                       input logic [3:0] code);
    rpsel_pkg::rpsel_route_t r;
    r.ok = 1'b0;
    r.hpc = 1'b0;
    r.pin = 6'd0;
    case (grp)
      rpsel_pkg::RPSEL_GRP_A: begin
        if (code <= 4'h8) begin
          r.ok = 1'b1;
          r.pin = {2'b00, code};
        end else if (code >= 4'ha && code <= 4'hd) begin
          r.ok = 1'b1;
          r.hpc = 1'b1;
          r.pin = {2'b00, code} - 6'd1;
        end else if (code == 4'hf) begin
          r.ok = 1'b1;
          r.pin = `RPS_PIN_F2;
        end
      end
      rpsel_pkg::RPSEL_GRP_B: begin
        if (code <= 4'h8) begin
          r.ok = 1'b1;
          r.pin = `RPS_BASE_B + {2'b00, code};
        end else if (code >= 4'ha && code <= 4'hd) begin
          r.ok = 1'b1;
          r.hpc = 1'b1;
          r.pin = `RPS_BASE_B + {2'b00, code} - 6'd1;
        end else if (code == 4'he) begin
          r.ok = 1'b1;
          r.pin = `RPS_PIN_F2;
        end else if (code == 4'hf) begin
          r.ok = 1'b1;
          r.pin = `RPS_PIN_F7;
        end
      end
      rpsel_pkg::RPSEL_GRP_C: begin
        if (code <= 4'h7) begin
          r.ok = 1'b1;
          r.pin = `RPS_BASE_C + {2'b00, code};
        end else if (code >= 4'h9 && code <= 4'hd) begin
          r.ok = 1'b1;
          r.hpc = 1'b1;
          r.pin = `RPS_BASE_C + {2'b00, code} - 6'd1;
        end else if (code == 4'hf) begin
          r.ok = 1'b1;
          r.pin = `RPS_BASE_C + 6'd13;
        end
      end
      default: begin
        r.ok = 1'b0;
      end
    endcase
    // Variant pruning of selections
    if (r.hpc && !PIN_COUNT_100) begin
      r.ok = 1'b0;
    end
    if (r.pin == `RPS_PIN_F2 && !HAS_F2) begin
      r.ok = 1'b0;
    end
    if (r.pin == `RPS_PIN_F7 && !HAS_F7) begin
      r.ok = 1'b0;
    end
    return r;
  endfunction

  // Select registers and peripheral routing
  logic [`RPS_SEL_W-1:0] sel_q [NPER];
  rpsel_pkg::rpsel_route_t route [NPER];
  logic [NPER-1:0] next_periph;
  logic [NPER-1:0] periph_q;

  // AXI write side
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [`RPS_DATA_W-1:0] w_data_q;
  logic [3:0] w_strb_q;
  wire aw_fire = s_axi_awvalid_in && awready_q;
  wire w_fire = s_axi_wvalid_in && wready_q;
  wire wr_fire = !awready_q && !wready_q && !bvalid_q;
  wire [IW-1:0] wr_idx = aw_addr_q[ADDR_W-1:2];
  wire wr_mapped = (wr_idx < NPER_IDX) || (wr_idx == LEVEL_IDX);

  genvar gi;
  generate
    for (gi = 0; gi < NPER; gi++) begin : g_per
      localparam rpsel_pkg::rpsel_grp_t GRP = (gi < `RPS_FIRST_GRP_B) ? rpsel_pkg::RPSEL_GRP_A :
                                              (gi < `RPS_FIRST_GRP_C) ? rpsel_pkg::RPSEL_GRP_B :
                                              rpsel_pkg::RPSEL_GRP_C;
      // Whole input missing on small packages
      localparam bit PRESENT = (gi != `RPS_PER_UART5_CTS) || PIN_COUNT_100;
      wire sel_wr = wr_fire && wr_idx == IW'(gi) && w_strb_q[0];

      assign route[gi] = route_of(GRP, sel_q[gi]);
      // Unrouted inputs sit at their idle level so peripherals see no edges
      assign next_periph[gi] = (route[gi].ok && PRESENT) ? pin_lvl[route[gi].pin] : IDLE[gi];

      always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
          sel_q[gi] <= `RPS_SEL_RESET;
        end else if (sel_wr) begin
          sel_q[gi] <= w_data_q[`RPS_SEL_W-1:0];
        end
      end
    end
  endgenerate

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      periph_q <= `RPS_IDLE_HIGH;
      change_notify_pins_out <= `RPS_CN_CAPABLE;
      out_remap_ok_out <= `RPS_OUT_REMAP_OK;
    end else begin
      periph_q <= next_periph;
      change_notify_pins_out <= `RPS_CN_CAPABLE;
      out_remap_ok_out <= `RPS_OUT_REMAP_OK;
    end
  end

  assign periph_out = rpsel_pkg::rpsel_periph_t'(periph_q);

  // Address and data may arrive in either order; the response waits for both
  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= `RPS_RESP_OKAY;
      aw_addr_q <= '0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end else begin
      if (aw_fire) begin
        awready_q <= 1'b0;
        aw_addr_q <= s_axi_awaddr_in;
      end
      if (w_fire) begin
        wready_q <= 1'b0;
        w_data_q <= s_axi_wdata_in;
        w_strb_q <= s_axi_wstrb_in;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? `RPS_RESP_OKAY : `RPS_RESP_DECERR;
      end else if (bvalid_q && s_axi_bready_in) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  assign s_axi_awready_out = awready_q;
  assign s_axi_wready_out = wready_q;
  assign s_axi_bvalid_out = bvalid_q;
  assign s_axi_bresp_out = bresp_q;

  // AXI read side; one read in flight, answered the cycle after the address
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [`RPS_DATA_W-1:0] rdata_q;
  wire ar_fire = s_axi_arvalid_in && arready_q;
  wire [IW-1:0] rd_idx = s_axi_araddr_in[ADDR_W-1:2];
  wire rd_is_sel = rd_idx < NPER_IDX;
  wire rd_is_level = rd_idx == LEVEL_IDX;
  wire [4:0] rd_sel_idx = rd_is_sel ? rd_idx[4:0] : 5'h00;
  wire [`RPS_DATA_W-1:0] rd_word = rd_is_sel ? {{(`RPS_DATA_W-`RPS_SEL_W){1'b0}}, sel_q[rd_sel_idx]} :
                                   rd_is_level ? {{(`RPS_DATA_W-NPER){1'b0}}, periph_q} :
                                   '0;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rresp_q <= `RPS_RESP_OKAY;
      rdata_q <= '0;
    end else if (ar_fire) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= (rd_is_sel || rd_is_level) ? `RPS_RESP_OKAY : `RPS_RESP_DECERR;
    end else if (rvalid_q && s_axi_rready_in) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign s_axi_arready_out = arready_q;
  assign s_axi_rvalid_out = rvalid_q;
  assign s_axi_rdata_out = rdata_q;
  assign s_axi_rresp_out = rresp_q;

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);

  // Select register, routing and filter checks; routing one or more per encoding group
  sel_write_a: assert property ($rose(bvalid_q) && wr_idx == '0 && w_strb_q[0]
    |-> ##1 sel_q[0] == $past(w_data_q[`RPS_SEL_W-1:0]) && bresp_q == `RPS_RESP_OKAY)
    else $error("select write lost");
  wstrb_guard_a: assert property (wr_fire && !w_strb_q[0]
    |=> $stable(sel_q[0]))
    else $error("select written with strobe low");
  read_sel_a: assert property (ar_fire && rd_is_sel && rd_idx == '0
    |=> rdata_q == {{(`RPS_DATA_W-`RPS_SEL_W){1'b0}}, $past(sel_q[0])})
    else $error("select read back wrong");
  irq3_route_a: assert property (sel_q[0] == 4'h3
    |=> periph_q[0] == $past(pin_lvl[3]))
    else $error("irq3 code 3 not D10");
  irq3_resv_a: assert property (sel_q[0] == 4'h9 || sel_q[0] == 4'he
    |=> periph_q[0] == 1'h0)
    else $error("reserved code drives irq3");
  tmr2_hpc_a: assert property (PIN_COUNT_100 && sel_q[1] == 4'ha
    |=> periph_q[1] == $past(pin_lvl[9]))
    else $error("timer2 clock code 10 not C1");
  rx1_route_a: assert property (sel_q[3] == 4'h0
    |=> periph_q[3] == $past(pin_lvl[14]))
    else $error("uart1 rx code 0 not D3");
  rx1_resv_a: assert property (sel_q[3] == 4'h9
    |=> periph_q[3] == 1'h1)
    else $error("reserved code drives uart1 rx");
  refclk_f7_a: assert property (sel_q[6] == 4'hf
    |=> periph_q[6] == (HAS_F7 ? $past(pin_lvl[27]) : 1'h0))
    else $error("refclk F7 routing wrong");
  irq4_route_a: assert property (sel_q[7] == 4'h1
    |=> periph_q[7] == $past(pin_lvl[29]))
    else $error("irq4 code 1 not G6");
  irq4_resv_a: assert property (sel_q[7] == 4'h8 || sel_q[7] == 4'he
    |=> periph_q[7] == 1'h0)
    else $error("reserved code drives irq4");
  spi1_din_a: assert property (sel_q[12] == 4'hf
    |=> periph_q[12] == $past(pin_lvl[41]))
    else $error("spi1 data code 15 not B2");
  slave_sel_resv_a: assert property (sel_q[20] == 4'h8
    |=> periph_q[20] == 1'h1)
    else $error("reserved code drives slave select");
  filter_hold_a: assert property (pin_s2[0] != pin_s3[0]
    |=> pin_lvl[0] == $past(pin_lvl[0]))
    else $error("pin level moved on a glitch");

  // Variant and mask checks
  f_input_only_a: assert property (!out_remap_ok_out[`RPS_PIN_F6]
    && !out_remap_ok_out[`RPS_PIN_F7] && out_remap_ok_out[26])
    else $error("port F output eligibility wrong");
  cn_f6_a: assert property (!change_notify_pins_out[`RPS_PIN_F6]
    && &change_notify_pins_out[41:0])
    else $error("change notify mask wrong");
  f2_absent_a: assert property (!HAS_F2 && sel_q[0] == 4'hf
    |=> periph_q[0] == 1'h0)
    else $error("F2 reached on small usb part");
  rx1_f2_a: assert property (sel_q[3] == 4'he
    |=> periph_q[3] == (HAS_F2 ? $past(pin_lvl[13]) : 1'h1))
    else $error("uart1 rx F2 routing wrong");
  hpc_absent_a: assert property (!PIN_COUNT_100 && sel_q[1] == 4'ha
    |=> periph_q[1] == 1'h0)
    else $error("flagged code live on 64-pin");
  irq4_hpc_a: assert property (sel_q[7] == 4'h9
    |=> periph_q[7] == (PIN_COUNT_100 ? $past(pin_lvl[36]) : 1'h0))
    else $error("irq4 flagged code routing wrong");
  cts5_absent_a: assert property (!PIN_COUNT_100
    |-> periph_q[`RPS_PER_UART5_CTS] == 1'h1)
    else $error("uart5 cts live on 64-pin");

  // Bus checks
  decerr_write_a: assert property ($rose(bvalid_q) && !wr_mapped
    |-> bresp_q == `RPS_RESP_DECERR)
    else $error("unmapped write not refused");
  status_read_a: assert property (ar_fire && rd_is_level
    |=> rdata_q[NPER-1:0] == $past(periph_q))
    else $error("status read wrong");
  r_answer_a: assert property (ar_fire
    |=> rvalid_q)
    else $error("read not answered next cycle");
  resp_ready_low_a: assert property (bvalid_q
    |-> !awready_q && !wready_q)
    else $error("write ready while answer stands");
  read_block_a: assert property (rvalid_q
    |-> !arready_q)
    else $error("read ready while answer stands");
  rvalid_hold_a: assert property (rvalid_q && !s_axi_rready_in
    |=> rvalid_q && $stable(rdata_q))
    else $error("read answer dropped");
  bvalid_hold_a: assert property (bvalid_q && !s_axi_bready_in
    |=> bvalid_q && $stable(bresp_q))
    else $error("write answer dropped");

endmodule

// ### tb/rpsel_pin_model.sv
/*
  Pad-side model: drives the remappable pin levels chosen by the bench.
  Assumes the bench sets level_in; pins move just after rising edges.
*/
`timescale 1ns/10ps
module rpsel_pin_model (
  input wire logic clk_in,
  input wire logic [42:0] level_in,
  output logic [42:0] pin_out
);
  // Registered, so no pin moves in the block's own sampling step
  always @(posedge clk_in) begin
    pin_out <= level_in;
  end
endmodule

// ### tb/rpsel_tb.sv
/*
  Self-checking bench for the remappable input pin select block.
  Assumes rpsel_top with a 100-pin and a 64-pin USB instance on one bus.
*/
`timescale 1ns/10ps
`include "rpsel_defs.svh"
module rpsel_tb;
  typedef struct {int r; logic [3:0] c; logic [5:0] p; bit ok_b; bit ok_s;} rpsel_row_t;
  logic sys_clk, rst_b, awvalid, wvalid, bready, arvalid, rready;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0] wstrb;
  logic [1:0] resp;
  logic [42:0] level;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdata;
  wire logic [42:0] pins, cn, oro;
  rpsel_pkg::rpsel_periph_t big_p, small_p;
  logic [20:0] pv_b, pv_s;
  int errors, tests_run;
  rpsel_row_t rows[$];
  assign pv_b = big_p;
  assign pv_s = small_p;

  rpsel_pin_model rpsel_pin_model_i (.clk_in(sys_clk), .level_in(level), .pin_out(pins));
  rpsel_top rpsel_top_i (.sys_clk_in(sys_clk), .rst_b_in(rst_b), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .remappable_pin_in(pins), .periph_out(big_p),
    .change_notify_pins_out(cn), .out_remap_ok_out(oro));
  // Same bus traffic; only its routes are watched
  rpsel_top #(.PIN_COUNT_100(1'b0), .USB_VARIANT(1'b1)) small_rpsel_top_i (.sys_clk_in(sys_clk),
    .rst_b_in(rst_b), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(),
    .s_axi_bresp_out(), .s_axi_bvalid_out(), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(), .s_axi_rdata_out(), .s_axi_rresp_out(),
    .s_axi_rvalid_out(), .s_axi_rready_in(rready), .remappable_pin_in(pins), .periph_out(small_p),
    .change_notify_pins_out(), .out_remap_ok_out());

  function automatic logic [5:0] map_pin(input int g, input logic [3:0] c);
    if (g == 0) begin
      if (c <= 4'h8) return 6'(c);
      if (c >= 4'ha && c <= 4'hd) return 6'(c) - 6'h01;
      if (c == 4'hf) return 6'h0d;
    end else if (g == 1) begin
      if (c <= 4'h8) return 6'h0e + 6'(c);
      if (c >= 4'ha && c <= 4'hd) return 6'h0d + 6'(c);
      if (c == 4'he) return 6'h0d;
      if (c == 4'hf) return 6'h1b;
    end else begin
      if (c <= 4'h7) return 6'h1c + 6'(c);
      if (c >= 4'h9 && c <= 4'hd) return 6'h1b + 6'(c);
      if (c == 4'hf) return 6'h29;
    end
    return 6'h3f;
  endfunction

  task automatic add_row(input int r, input logic [3:0] c);
    rpsel_row_t w;
    int g;
    bit hpc;
    g = (r < 3) ? 0 : ((r < 7) ? 1 : 2);
    hpc = (g < 2) ? (c >= 4'ha && c <= 4'hd) : (c >= 4'h9 && c <= 4'hd);
    w.r = r;
    w.c = c;
    w.p = map_pin(g, c);
    w.ok_b = (w.p != 6'h3f);
    w.ok_s = w.ok_b && w.p != 6'h0d && w.p != 6'h1b && !hpc && r != 5;
    rows.push_back(w);
  endtask

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] s);
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= v;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        resp = bresp;
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge sys_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        resp = rresp;
        d = rdata;
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic results;
    $display("tests_run=%0d errors=%0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    errors++;
    results();
  end

  initial begin
    {rst_b, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata, wstrb, level} <= '0;
    repeat (8) @(posedge sys_clk);
    chk(pv_b, `RPS_IDLE_HIGH);
    rst_b <= 1'b1;
    chk(cn, 43'(~(43'h1 << 42)));
    chk(oro, 43'(~((43'h1 << 42) | (43'h1 << 27))));
    $display("reset and masks done");
    for (int c = 0; c < 16; c++) add_row(0, 4'(c));
    for (int c = 0; c < 16; c++) add_row(3, 4'(c));
    for (int c = 0; c < 16; c++) add_row(7, 4'(c));
    for (int r = 0; r < 21; r++) add_row(r, 4'h3);
    add_row(1, 4'ha);
    foreach (rows[i]) begin
      // Select written before this row drives its pin levels
      wr(12'(4 * rows[i].r), {28'h0, rows[i].c}, 4'hf);
      chk(resp, `RPS_RESP_OKAY);
      rd(12'(4 * rows[i].r));
      chk(d, {28'h0, rows[i].c});
      for (int ph = 0; ph < 2; ph++) begin
        level <= ph ? ~(43'h1 << rows[i].p) : (43'h1 << rows[i].p);
        repeat (10) @(posedge sys_clk);
        chk(pv_b[rows[i].r], rows[i].ok_b ? !ph : `RPS_IDLE_HIGH >> rows[i].r & 1);
        chk(pv_s[rows[i].r], rows[i].ok_s ? !ph : `RPS_IDLE_HIGH >> rows[i].r & 1);
      end
    end
    $display("route table done");
    wr(12'h000, 32'hffff_fff5, 4'hf);
    wr(12'h000, 32'h0000_0009, 4'h0);
    chk(resp, `RPS_RESP_OKAY);
    rd(12'h000);
    chk(d, 32'h0000_0005);
    wr(12'h058, 32'h0000_0001, 4'hf);
    chk(resp, `RPS_RESP_DECERR);
    rd(12'h058);
    chk({resp, d}, {`RPS_RESP_DECERR, 32'h0});
    wr(12'h054, 32'h0000_0001, 4'hf);
    chk(resp, `RPS_RESP_OKAY);
    $display("bus edge cases done");
    level <= '0;
    rst_b <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk(pv_b, `RPS_IDLE_HIGH);
    rst_b <= 1'b1;
    rd(12'h000);
    chk(d, 32'h0);
    repeat (10) @(posedge sys_clk);
    chk(pv_b, 21'h0);
    chk(pv_s, 21'h20);
    rd(12'h054);
    chk(d, 32'h0);
    $display("mid-run reset done");
    results();
  end
endmodule
